// ===== shared/pmbus_vout_consts.vh
// Purpose: Shared constants for the bus slave, output setting and OTP check.
// Assumes: A 40 MHz system clock.
// Notes:   Timing counts are derived from the printed times.
`ifndef PMBUS_VOUT_CONSTS_VH
`define PMBUS_VOUT_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  25
`define T_BUF_NS       4700
`define T_BUF_CYC      ((`T_BUF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_WAIT     2'h3

// ----------------------------------------------------------------
// Addressing and commands
// ----------------------------------------------------------------
`define ADDR_BASE      7'h21
`define ADDR_SEL_MAX   3'h6
`define VOUT_CMD       8'h21
`define VOUT_CODE_5V   8'h04
`define VOUT_CODE_MAX  8'h07

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define CML_BIT        1
`define MFR_OTP_BIT    0
`define STATUS_RST     8'h00

// ----------------------------------------------------------------
// OTP check
// ----------------------------------------------------------------
`define OTP_RETRIES    2'h2
`define OTP_PAGES      4
`define CRC_POLY       8'h07
`define CRC_INIT       8'h00

`endif

// ===== hdl/otp_crc_check.v
// Purpose: Loads an OTP page, checks its CRC, retries and falls back.
// Assumes: The OTP macro runs on mclk_i; its last byte of a page is the CRC.
// Notes:   A page is good when the CRC over all its bytes comes out zero.
`timescale 1ns/10ps
`include "pmbus_vout_consts.vh"

module otp_crc_check (
    input  wire       mclk_i,
    input  wire       rst_b_i,
    input  wire       start_i,
    input  wire [7:0] otp_data_i,
    input  wire       otp_valid_i,
    input  wire       otp_last_i,
    input  wire [3:0] otp_avail_i,
    output reg        otp_rd_o,
    output reg  [1:0] otp_page_o,
    output reg        done_o,
    output reg        fail_o
);

    localparam [2:0] S_FIND  = 3'h0;
    localparam [2:0] S_REQ   = 3'h1;
    localparam [2:0] S_WAIT  = 3'h2;
    localparam [2:0] S_CHECK = 3'h3;
    localparam [2:0] S_DONE  = 3'h4;
    localparam [2:0] S_FAIL  = 3'h5;

    reg [2:0] state_reg;
    reg [1:0] tries_reg;
    reg [2:0] from_reg;
    reg [7:0] crc_reg;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [7:0] crc_byte;
        input [7:0] crc;
        input [7:0] data;
        integer i;
        reg [7:0] c;
        begin
            c = crc ^ data;
            for (i = 0; i < 8; i = i + 1) begin
                c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
            end
            crc_byte = c;
        end
    endfunction

    // Returns {found, index} of the first available page at or above from.
    function [2:0] next_page;
        input [3:0] avail;
        input [2:0] from;
        integer i;
        reg [2:0] r;
        begin
            r = 3'h0;
            for (i = `OTP_PAGES - 1; i >= 0; i = i - 1) begin
                if (avail[i] && (i >= from)) begin
                    r = {1'b1, i[1:0]};
                end
            end
            next_page = r;
        end
    endfunction

    wire [2:0] pick = next_page(otp_avail_i, from_reg);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_reg  <= S_FIND;
            tries_reg  <= 2'h0;
            from_reg   <= 3'h0;
            crc_reg    <= `CRC_INIT;
            otp_rd_o   <= 1'b0;
            otp_page_o <= 2'h0;
            done_o     <= 1'b0;
            fail_o     <= 1'b0;
        end else begin
            otp_rd_o <= 1'b0;
            if (start_i && (state_reg != S_REQ) && (state_reg != S_WAIT)) begin
                state_reg <= S_FIND;
                from_reg  <= 3'h0;
                done_o    <= 1'b0;
                fail_o    <= 1'b0;
            end else begin
                case (state_reg)
                    S_FIND: begin
                        tries_reg <= 2'h0;
                        if (pick[2]) begin
                            otp_page_o <= pick[1:0];
                            state_reg  <= S_REQ;
                        end else begin
                            fail_o    <= 1'b1;
                            state_reg <= S_FAIL;
                        end
                    end
                    S_REQ: begin
                        otp_rd_o  <= 1'b1;
                        crc_reg   <= `CRC_INIT;
                        state_reg <= S_WAIT;
                    end
                    S_WAIT: begin
                        if (otp_valid_i) begin
                            crc_reg <= crc_byte(crc_reg, otp_data_i);
                            if (otp_last_i) begin
                                state_reg <= S_CHECK;
                            end
                        end
                    end
                    S_CHECK: begin
                        if (crc_reg == 8'h00) begin
                            done_o    <= 1'b1;
                            state_reg <= S_DONE;
                        end else if (tries_reg != `OTP_RETRIES) begin
                            tries_reg <= tries_reg + 2'h1;
                            state_reg <= S_REQ;
                        end else begin
                            from_reg  <= {1'b0, otp_page_o} + 3'h1;
                            state_reg <= S_FIND;
                        end
                    end
                    S_DONE: begin
                        state_reg <= S_DONE;
                    end
                    S_FAIL: begin
                        state_reg <= S_FAIL;
                    end
                    default: begin
                        state_reg <= S_FIND;
                    end
                endcase
            end
        end
    end

endmodule

// ===== hdl/pmbus_vout_slave.v
// Purpose: Bus slave that sets the output target, plus OTP integrity status.
// Assumes: scl_i and sda_i are the resolved bus levels; strap code is 0..6.
// Notes:   Write-only slave; reads are acknowledged and return all ones.
`timescale 1ns/10ps
`include "pmbus_vout_consts.vh"

module pmbus_vout_slave (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    input  wire        en_i,
    input  wire        uvlo_ok_i,
    input  wire [2:0]  addr_sel_i,
    input  wire [7:0]  otp_data_i,
    input  wire        otp_valid_i,
    input  wire        otp_last_i,
    input  wire [3:0]  otp_avail_i,
    input  wire        otp_reload_i,
    output wire        otp_rd_o,
    output wire [1:0]  otp_page_o,
    output wire        cfg_ok_o,
    output reg         regulate_o,
    output reg         vout_prog_o,
    output reg  [7:0]  ref_sel_o,
    output reg  [2:0]  div_sel_o,
    output reg         bus_busy_o,
    output reg  [7:0]  status_byte_o,
    output reg  [15:0] status_word_o,
    output reg  [7:0]  status_mfr_o,
    output reg         alert_out_n_o
);

    // ----------------------------------------------------------------
    // States and local constants
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_ADDR     = 3'h1;
    localparam [2:0] ST_ACK_ADDR = 3'h2;
    localparam [2:0] ST_REG      = 3'h3;
    localparam [2:0] ST_ACK_REG  = 3'h4;
    localparam [2:0] ST_DATA     = 3'h5;
    localparam [2:0] ST_ACK_DATA = 3'h6;
    localparam [2:0] ST_IGNORE   = 3'h7;

    localparam integer BUF_CYC_FULL = `T_BUF_CYC;
    localparam [7:0]   BUF_CYC      = BUF_CYC_FULL[7:0];

    // ----------------------------------------------------------------
    // Output setting table
    // ----------------------------------------------------------------
    // Returns {divider, reference} for a setting code.
    function [10:0] vout_table;
        input [7:0] code;
        begin
            case (code[2:0])
                3'h0:    vout_table = {3'h0, 8'h50};
                3'h1:    vout_table = {3'h0, 8'h78};
                3'h2:    vout_table = {3'h1, 8'h6E};
                3'h3:    vout_table = {3'h2, 8'h84};
                3'h4:    vout_table = {3'h3, 8'hA0};
                3'h5:    vout_table = {3'h3, 8'hC0};
                3'h6:    vout_table = {3'h4, 8'hB4};
                default: vout_table = {3'h5, 8'hC8};
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg        scl_m_reg;
    reg        scl_s_reg;
    reg        scl_d_reg;
    reg        sda_m_reg;
    reg        sda_s_reg;
    reg        sda_d_reg;
    reg        en_m_reg;
    reg        en_s_reg;
    reg        uv_m_reg;
    reg        uv_s_reg;
    reg  [2:0] sel_m_reg;
    reg  [2:0] sel_s_reg;
    reg  [1:0] strap_cnt_reg;
    reg        strap_done_reg;
    reg  [6:0] own_addr_reg;
    reg  [2:0] state_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] reg_addr_reg;
    reg        rd_reg;
    reg  [7:0] free_cnt_reg;
    reg        otp_start_reg;
    wire       otp_done;
    wire       otp_fail;
    wire [2:0] sel_clamp;
    wire [10:0] tt_def;
    wire [10:0] tt_new;

    // ----------------------------------------------------------------
    // Pin synchronisers and bus events
    // ----------------------------------------------------------------
    // At 3.4 MHz the SCL high phase is only a few clocks long; the
    // three-stage path leaves enough margin but a slower core would not.
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            en_m_reg  <= 1'b0;
            en_s_reg  <= 1'b0;
            uv_m_reg  <= 1'b0;
            uv_s_reg  <= 1'b0;
            sel_m_reg <= 3'h0;
            sel_s_reg <= 3'h0;
        end else begin
            scl_m_reg <= scl_i;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= sda_i;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
            en_m_reg  <= en_i;
            en_s_reg  <= en_m_reg;
            uv_m_reg  <= uvlo_ok_i;
            uv_s_reg  <= uv_m_reg;
            sel_m_reg <= addr_sel_i;
            sel_s_reg <= sel_m_reg;
        end
    end

    wire scl_rise = scl_s_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s_reg & scl_d_reg;
    wire start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    wire stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

    // ----------------------------------------------------------------
    // Address strap
    // ----------------------------------------------------------------
    // The strap is caught once, a few clocks after reset release, so the
    // synchroniser has settled; later changes on the pin are ignored.
    assign sel_clamp = (sel_s_reg > `ADDR_SEL_MAX) ? `ADDR_SEL_MAX : sel_s_reg;

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
            own_addr_reg   <= `ADDR_BASE;
        end else if (!strap_done_reg) begin
            if (strap_cnt_reg == `STRAP_WAIT) begin
                own_addr_reg   <= `ADDR_BASE + {4'h0, sel_clamp};
                strap_done_reg <= 1'b1;
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus busy tracking
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            bus_busy_o   <= 1'b0;
            free_cnt_reg <= 8'h00;
        end else if (start_det) begin
            bus_busy_o   <= 1'b1;
            free_cnt_reg <= 8'h00;
        end else if (stop_det) begin
            free_cnt_reg <= BUF_CYC;
        end else if (free_cnt_reg != 8'h00) begin
            free_cnt_reg <= free_cnt_reg - 8'h01;
            if (free_cnt_reg == 8'h01) begin
                bus_busy_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Slave byte engine
    // ----------------------------------------------------------------
    // Bytes are sampled on SCL rising and acted on at the falling edge
    // after the eighth bit, so SDA only ever changes while SCL is low.
    assign tt_new = vout_table(shift_reg);
    assign tt_def = vout_table(`VOUT_CODE_5V);

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            reg_addr_reg  <= 8'h00;
            rd_reg        <= 1'b0;
            sda_o         <= 1'b0;
            sda_oe_o      <= 1'b0;
            vout_prog_o   <= 1'b0;
            ref_sel_o     <= tt_def[7:0];
            div_sel_o     <= tt_def[10:8];
        end else if (start_det) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_o    <= 1'b0;
        end else if (stop_det) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            sda_oe_o    <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_REG, ST_DATA: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && (bit_cnt_reg == 4'h8)) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == own_addr_reg) begin
                                rd_reg    <= shift_reg[0];
                                sda_oe_o  <= 1'b1;
                                state_reg <= ST_ACK_ADDR;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end else if (state_reg == ST_REG) begin
                            reg_addr_reg <= shift_reg;
                            sda_oe_o     <= 1'b1;
                            state_reg    <= ST_ACK_REG;
                        end else begin
                            sda_oe_o  <= 1'b1;
                            state_reg <= ST_ACK_DATA;
                            if ((reg_addr_reg == `VOUT_CMD) &&
                                (shift_reg <= `VOUT_CODE_MAX)) begin
                                vout_prog_o   <= 1'b1;
                                ref_sel_o     <= tt_new[7:0];
                                div_sel_o     <= tt_new[10:8];
                            end
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA: begin
                    if (scl_fall) begin
                        sda_oe_o <= 1'b0;
                        if (state_reg == ST_ACK_ADDR) begin
                            state_reg <= rd_reg ? ST_IGNORE : ST_REG;
                        end else begin
                            state_reg <= ST_DATA;
                        end
                    end
                end
                ST_IGNORE: begin
                    sda_oe_o <= 1'b0;
                end
                ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power stage enable
    // ----------------------------------------------------------------
    // The target itself stays at the reset default until a write lands,
    // so enabling before any write comes up at the default output.
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            regulate_o <= 1'b0;
        end else begin
            regulate_o <= en_s_reg & uv_s_reg;
        end
    end

    // ----------------------------------------------------------------
    // OTP load and integrity status
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            otp_start_reg <= 1'b0;
        end else begin
            otp_start_reg <= otp_reload_i;
        end
    end

    otp_crc_check u_otp (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .start_i     (otp_start_reg),
        .otp_data_i  (otp_data_i),
        .otp_valid_i (otp_valid_i),
        .otp_last_i  (otp_last_i),
        .otp_avail_i (otp_avail_i),
        .otp_rd_o    (otp_rd_o),
        .otp_page_o  (otp_page_o),
        .done_o      (otp_done),
        .fail_o      (otp_fail)
    );

    assign cfg_ok_o = otp_done;

    // Status bits are sticky; nothing in this block clears them, so a
    // failed load is only forgotten by a reset.
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            status_byte_o <= `STATUS_RST;
            status_word_o <= {`STATUS_RST, `STATUS_RST};
            status_mfr_o  <= `STATUS_RST;
            alert_out_n_o <= 1'b1;
        end else if (otp_fail) begin
            status_byte_o[`CML_BIT] <= 1'b1;
            status_word_o[`CML_BIT] <= 1'b1;
            status_mfr_o[`MFR_OTP_BIT] <= 1'b1;
            alert_out_n_o <= 1'b0;
        end
    end

endmodule

// ===== bench/pmbus_vout_slave_props.sv
// Purpose: Temporal checks on the bus slave ports.
// Assumes: 40 MHz clock; SCL high and low phases of at least 3 clocks.
// Notes:   Retries are counted per page so a missing or extra read shows.
`timescale 1ns/10ps
`include "pmbus_vout_consts.vh"
module pmbus_vout_props (
    input wire        mclk_i,
    input wire        rst_b_i,
    input wire        scl_i,
    input wire        sda_i,
    input wire        sda_oe_o,
    input wire        en_i,
    input wire        uvlo_ok_i,
    input wire        otp_reload_i,
    input wire        otp_rd_o,
    input wire [1:0]  otp_page_o,
    input wire        regulate_o,
    input wire        vout_prog_o,
    input wire [7:0]  ref_sel_o,
    input wire [2:0]  div_sel_o,
    input wire        bus_busy_o,
    input wire [7:0]  status_byte_o,
    input wire [15:0] status_word_o,
    input wire [7:0]  status_mfr_o,
    input wire        alert_out_n_o
);
    logic [1:0] rd_cnt_reg;
    logic [1:0] pg_reg;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    always @(posedge mclk_i) begin
        if (!rst_b_i || otp_reload_i) begin
            rd_cnt_reg <= 2'h0;
            pg_reg     <= 2'h0;
        end else if (otp_rd_o) begin
            rd_cnt_reg <= (otp_page_o == pg_reg && rd_cnt_reg != 2'h0) ? rd_cnt_reg + 2'h1 : 2'h1;
            pg_reg     <= otp_page_o;
        end
    end
    a_regulate_on: assert property ((en_i && uvlo_ok_i)[*6] |-> regulate_o)
        else $error("regulate low while enabled");
    a_regulate_off: assert property ((!en_i)[*6] |-> !regulate_o)
        else $error("regulate high while disabled");
    a_default_set: assert property (!vout_prog_o |-> ref_sel_o == 8'hA0 && div_sel_o == 3'h3)
        else $error("default setting lost");
    a_table_entry: assert property ($changed({div_sel_o, ref_sel_o}) |-> vout_prog_o &&
        ({div_sel_o, ref_sel_o} inside {11'h050, 11'h078, 11'h16E, 11'h284, 11'h3A0, 11'h3C0, 11'h4B4, 11'h5C8}))
        else $error("setting outside table");
    a_ack_low_scl: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda changed with scl high");
    a_start_busy: assert property (scl_i && $fell(sda_i) |-> ##[1:6] bus_busy_o)
        else $error("busy missing after start");
    a_stop_free: assert property ($fell(bus_busy_o) |-> $past(scl_i && sda_i, 180))
        else $error("bus freed too early");
    a_retry_limit: assert property (otp_rd_o && otp_page_o == pg_reg |-> rd_cnt_reg != 2'h3)
        else $error("page read more than three times");
    a_fail_retries: assert property ($fell(alert_out_n_o) |-> rd_cnt_reg == 2'h3)
        else $error("alert before retries done");
    a_alert_status: assert property (!alert_out_n_o |-> status_byte_o[`CML_BIT] &&
        status_word_o[`CML_BIT] && status_mfr_o[`MFR_OTP_BIT])
        else $error("alert without status bits");
    cover property ($fell(alert_out_n_o));
    cover property ($rose(vout_prog_o));
    cover property (scl_i && $rose(sda_i));
endmodule
bind pmbus_vout_slave pmbus_vout_props props_u (.mclk_i, .rst_b_i, .scl_i, .sda_i, .sda_oe_o, .en_i, .uvlo_ok_i,
    .otp_reload_i, .otp_rd_o, .otp_page_o, .regulate_o, .vout_prog_o, .ref_sel_o, .div_sel_o, .bus_busy_o,
    .status_byte_o, .status_word_o, .status_mfr_o, .alert_out_n_o);

// ===== bench/pmbus_master_model.sv
// Purpose: Bus master model pulling SCL and SDA as open-drain lines.
// Assumes: 200 ns SCL period, five clocks low and three high.
// Notes:   Lines are only pulled low; a release lets the pull-up win.
`timescale 1ns/10ps
module pmbus_master_model (
    input  wire  mclk_i,
    input  wire  sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // SDA moves mid low phase, so the slave's answer has settled by the rise.
    task automatic bit_t(input logic b, output logic s);
        scl_oe_o = 1'b1;
        w(2);
        sda_oe_o = !b;
        w(3);
        scl_oe_o = 1'b0;
        w(2);
        s = sda_i;
        w(1);
    endtask
    task automatic cond(input logic first, input logic last);
        scl_oe_o = 1'b1;
        w(2);
        sda_oe_o = first;
        w(3);
        scl_oe_o = 1'b0;
        w(3);
        sda_oe_o = last;
        w(3);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_t(d[i], s);
        bit_t(1'b1, s);
        ack = !s;
    endtask
endmodule

// ===== bench/pmbus_vout_slave_tb.sv
// Purpose: Self-checking bench for the bus slave and OTP check.
// Assumes: Strap code 2, so the slave answers at 23h.
// Notes:   OTP pages are one byte each, which is also the CRC byte.
`timescale 1ns/10ps
module pmbus_vout_slave_tb;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, en_i = 1'b1, uvlo_ok_i = 1'b1;
    logic [7:0] otp_data_i = 8'h00, obyte = 8'h00;
    logic otp_valid_i = 1'b0, otp_last_i = 1'b0, otp_reload_i = 1'b0;
    logic scl_oe, sda_oe_m, sda_oe_o, sda_o, otp_rd_o, cfg_ok_o, regulate_o, vout_prog_o, bus_busy_o, alert_out_n_o;
    logic [1:0] otp_page_o;
    logic [7:0] ref_sel_o, status_byte_o, status_mfr_o;
    logic [2:0] div_sel_o;
    logic [15:0] status_word_o;
    logic [11:0] pg_log = 12'h000;
    logic [3:0] avail = 4'h3;
    int n_fail = 0, checks = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe_m || sda_oe_o);
    logic [10:0] tbl [8] = '{11'h050, 11'h078, 11'h16E, 11'h284, 11'h3A0, 11'h3C0, 11'h4B4, 11'h5C8};
    always #12.5 mclk_i = !mclk_i;
    pmbus_master_model master_u (.mclk_i(mclk_i), .sda_i(sda), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe_m));
    pmbus_vout_slave dut_u (.mclk_i, .rst_b_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o, .en_i, .uvlo_ok_i,
        .addr_sel_i(3'h2), .otp_data_i, .otp_valid_i, .otp_last_i, .otp_avail_i(avail), .otp_reload_i, .otp_rd_o,
        .otp_page_o, .cfg_ok_o, .regulate_o, .vout_prog_o, .ref_sel_o, .div_sel_o, .bus_busy_o, .status_byte_o,
        .status_word_o, .status_mfr_o, .alert_out_n_o);
    always @(negedge mclk_i) begin
        otp_valid_i <= otp_rd_o;
        otp_last_i <= otp_rd_o;
        otp_data_i <= obyte;
        if (otp_rd_o) pg_log <= {pg_log[9:0], otp_page_o};
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // The gap after each stop keeps the master clear of the bus free time.
    task automatic xfer(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, input logic hit,
                        input logic [10:0] e);
        logic k;
        master_u.cond(1'b0, 1'b1);
        master_u.send({a, 1'b0}, k);
        chk("addr ack", k, hit);
        master_u.send(r, k);
        chk("reg ack", k, hit);
        master_u.send(d, k);
        chk("data ack", k, hit);
        chk("setting", {div_sel_o, ref_sel_o}, e);
        master_u.cond(1'b1, 1'b0);
        repeat (150) @(negedge mclk_i);
        chk("busy held", bus_busy_o, 1'b1);
        repeat (50) @(negedge mclk_i);
        chk("busy free", bus_busy_o, 1'b0);
    endtask
    task automatic t_boot;
        chk("cfg ok", cfg_ok_o, 1'b1);
        chk("default", {vout_prog_o, div_sel_o, ref_sel_o}, 12'h3A0);
        chk("regulate", regulate_o, 1'b1);
        chk("sda level", sda_o, 1'b0);
        en_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk("regulate off", regulate_o, 1'b0);
        en_i = 1'b1;
        uvlo_ok_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk("regulate uvlo", regulate_o, 1'b0);
        uvlo_ok_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        chk("regulate back", regulate_o, 1'b1);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 8; c++) xfer(7'h23, 8'h21, c[7:0], 1'b1, tbl[c]);
        chk("prog", vout_prog_o, 1'b1);
    endtask
    task automatic t_refuse;
        xfer(7'h23, 8'h21, 8'h08, 1'b1, tbl[7]);
        xfer(7'h23, 8'h22, 8'h02, 1'b1, tbl[7]);
        xfer(7'h21, 8'h21, 8'h02, 1'b0, tbl[7]);
    endtask
    task automatic t_rstart;
        logic k;
        master_u.cond(1'b0, 1'b1);
        master_u.send(8'h42, k);
        chk("miss ack", k, 1'b0);
        master_u.cond(1'b0, 1'b1);
        master_u.send(8'h47, k);
        chk("read ack", k, 1'b1);
        xfer(7'h23, 8'h21, 8'h05, 1'b1, tbl[5]);
    endtask
    task automatic t_otp;
        obyte = 8'h01;
        avail = 4'hA;
        otp_reload_i = 1'b1;
        @(negedge mclk_i);
        otp_reload_i = 1'b0;
        for (int i = 0; i < 400 && alert_out_n_o !== 1'b0; i++) @(negedge mclk_i);
        chk("pages", {4'h0, pg_log}, 16'h057F);
        chk("cfg lost", cfg_ok_o, 1'b0);
        chk("status", {status_byte_o[1], status_word_o[1], status_mfr_o[0], alert_out_n_o}, 4'hE);
    endtask
    initial begin
        repeat (8) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        t_boot;
        t_codes;
        t_refuse;
        t_rstart;
        t_otp;
        results;
    end
    initial begin
        repeat (40000) @(posedge mclk_i);
        n_fail++;
        results;
    end
endmodule
